// file: common/nic_defs.vh
/*
 Constants of the nested priority interrupt controller: register indices,
 reset values, priority codes, vector numbers and wake masks.
 Assumes inclusion by the controller, monitor and bench files.
*/
`ifndef NIC_DEFS_VH
`define NIC_DEFS_VH

// Register indices; the APB byte address is four times the index.
`define NIC_IDX_CC       8'h20
`define NIC_IDX_SW_PRIORITY_0    8'h25
`define NIC_IDX_SW_PRIORITY_1    8'h26
`define NIC_IDX_SW_PRIORITY_2    8'h27
`define NIC_IDX_SW_PRIORITY_3    8'h28
`define NIC_IDX_EXTSENS  8'h29
`define NIC_IDX_TLICTL   8'h2a
`define NIC_IDX_STATUS   8'h2b

// Reset values.
`define NIC_RST_ISPR     8'hff
`define NIC_RST_EXTSENS  8'h00
`define NIC_RST_TLICTL   2'h0
`define NIC_RST_PREV     1'b1

// Priority codes held as {hi,lo}.
`define NIC_CODE_L0      2'h2
`define NIC_CODE_L1      2'h1
`define NIC_CODE_L2      2'h0
`define NIC_CODE_L3      2'h3

// Sensitivity codes of an external source.
`define NIC_SENS_FALL_LOW 2'h0
`define NIC_SENS_RISE     2'h1
`define NIC_SENS_FALL     2'h2
`define NIC_SENS_BOTH     2'h3

// Vector addresses and numbering.
`define NIC_VEC_TOP      16'hfffa
`define NIC_VEC_TRAP     16'hfffc
`define NIC_EXT_FIRST    2

// Sources that leave halt and active halt by their peripheral request.
`define NIC_WAKE_HALT    14'h2104
`define NIC_WAKE_ACTIVE  14'h2106

`endif

// file: core/nic_ext_detect.v
/*
 One external interrupt source: edge or level detection with a pending latch.
 Assumes the pin is synchronous to pclk.
*/
`timescale 1ns/1ps
`include "nic_defs.vh"

module nic_ext_detect (
   // Clock and reset
   input  wire       pclk,
   input  wire       presetn,
   // Source
   input  wire       pin,
   input  wire [1:0] sens,
   input  wire       clr,
   // Result
   output reg        pend
);

   reg  prev;
   wire rise;
   wire fall;
   reg  hit;

   assign rise = pin & ~prev;
   assign fall = ~pin & prev;

   // Selects the event that sets the latch.
   always @* begin
      case (sens)
         `NIC_SENS_FALL_LOW: hit = fall | ~pin; // R21
         `NIC_SENS_RISE:     hit = rise;
         `NIC_SENS_FALL:     hit = fall;
         default:            hit = rise | fall;
      endcase
   end

   // A new event in the clearing cycle wins over the clear.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev <= `NIC_RST_PREV;
         pend <= 1'b0;
      end else begin
         prev <= pin;
         if (hit)
            pend <= 1'b1;
         else if (clr)
            pend <= 1'b0;
      end
   end

endmodule

// file: core/nic_top.v
/*
 Nested priority interrupt controller with an APB register slave.
 Holds the current priority level, per-vector software priorities, external
 source sensitivity and the top level source, ranks pending requests and
 hands the winning vector to the core at the end of an instruction.
 Assumes the core reports its instruction events as one-cycle pulses and
 peripheral requests as levels that the peripherals clear themselves.
*/
// Decided for this implementation: the address map and the APB interface to the registers.
// Notes on behaviour
// R01: Current level is two bits, shown at bits 5 and 3 of the code register.
// R02: Codes hi:lo are 10 level 0, 01 level 1, 00 level 2, 11 disabled.
// R03: Entering a maskable service loads the vector's stored priority pair.
// R04: After reset the code register reads 1110 1010, level 3.
// R05: Priority registers reset to ones; top nibble of the fourth reads one.
// R06: Vector n owns pair n; reset and trap own none.
// R07: A pair written with the level 0 code keeps its old value.
// R08: Reset, trap and top level service set both priority bits.
// R09: Top level, trap and reset interrupt a level 3 program.
// R10: Top level pair is stored but ignored by arbitration.
// R11: Raised priority of a running pending vector re-enters it, else waits.
// R12: Enable, halt, wait load 10; disable, trap load 11; return, pop restore.
// R13: Level-3 jump taken when pair is 11; the other when it is not.
// R14: Instruction changes inside a routine hold until next return or change.
// R15: Equal software priority resolves by vector number, lowest first.
// R16: Halt wake applies to both halts; clock source only active, voltage never.
// R17: Serial interrupt does not wake from halt; external pin interrupts do.
// R18: Four external sources, each edge or level selectable.
// R19: Software changes sensitivity only at level 3.
// R20: Changing a source's sensitivity clears its pending latch.
// R21: Sensitivity 00 fall plus low, 01 rise, 10 fall, 11 both.
// R22: Maskable request served only above current level, otherwise pending.
// R23: One pending latch per vector; winner presented at instruction end.
`timescale 1ns/1ps
`include "nic_defs.vh"

module nic_top #(
   parameter NVEC = 14,
   parameter NEXT = 4
) (
   // Clock and reset
   input  wire            pclk,
   input  wire            presetn,
   // APB slave
   input  wire            psel,
   input  wire            penable,
   input  wire            pwrite,
   input  wire [11:0]     paddr,
   input  wire [31:0]     pwdata,
   output reg  [31:0]     prdata,
   output reg             pready,
   output reg             pslverr,
   // Core instruction events
   input  wire            instr_end,
   input  wire            irq_enable_instr,
   input  wire            irq_disable_instr,
   input  wire            halt_instr,
   input  wire            wait_for_irq_instr,
   input  wire            trap_instr,
   input  wire            irq_return_instr,
   input  wire            pop_cc_instr,
   input  wire [1:0]      stack_prio,
   // Power modes
   input  wire            halt_mode,
   input  wire            active_halt_mode,
   // Interrupt sources
   input  wire [NVEC-1:0] periph_irq,
   input  wire            aux_volt_detect,
   input  wire [NEXT-1:0] ext_pin,
   input  wire            tli_pin,
   // Service and status to the core
   output reg             svc_valid,
   output reg  [15:0]     svc_vector,
   output reg             cc_prio_hi,
   output reg             cc_prio_lo,
   output reg             level3_jump_take,
   output reg             wake_req
);

   reg  [2*NVEC-1:0] prio;
   reg  [2*NEXT-1:0] ext_sens;
   reg               tli_sens;
   reg               tli_en;
   wire [NEXT-1:0]   ext_pend;
   wire              tli_pend;
   reg  [NEXT-1:0]   ext_clr;
   reg               tli_clr;
   reg  [1:0]        next_cc;
   reg               next_svc;
   reg  [15:0]       next_vec;
   wire [1:0]        cc;
   wire              apb_wr;
   wire              apb_rd;
   wire [7:0]        idx;
   reg  [NVEC-1:0]   pend;
   reg  [NVEC-1:0]   wake_src;
   reg  [NVEC-1:0]   wake_ok;
   wire              in_halt;
   reg               found;
   reg  [1:0]        best_lvl;
   reg  [3:0]        best_idx;
   reg  [31:0]       rd_mux;
   reg               rd_hit;
   integer           i;
   integer           j;
   integer           k;
   integer           n;

   assign cc      = {cc_prio_hi, cc_prio_lo};
   assign idx     = paddr[9:2];
   assign apb_wr  = psel & penable & pready & pwrite & ~(|paddr[11:10]);
   assign apb_rd  = psel & penable & ~pready & ~pwrite;
   assign in_halt = halt_mode | active_halt_mode;

   // Converts a stored pair into its nesting level.
   function [1:0] lvl;
      input [1:0] code;
      begin
         case (code)
            `NIC_CODE_L0: lvl = 2'h0; // R02
            `NIC_CODE_L1: lvl = 2'h1;
            `NIC_CODE_L2: lvl = 2'h2;
            default:      lvl = 2'h3;
         endcase
      end
   endfunction

   // Merges a written pair, keeping the old one on a level 0 code.
   function [1:0] merge;
      input [1:0] old_code;
      input [1:0] new_code;
      begin
         if (new_code == `NIC_CODE_L0)
            merge = old_code; // R07
         else
            merge = new_code;
      end
   endfunction

   // External sources, one per vector from the first external vector on.
   genvar g;
   generate
      for (g = 0; g < NEXT; g = g + 1) begin : gen_ext
         nic_ext_detect u_det (
            .pclk    (pclk),
            .presetn (presetn),
            .pin     (ext_pin[g]),
            .sens    (ext_sens[2*g+1:2*g]), // R18
            .clr     (ext_clr[g]),
            .pend    (ext_pend[g])
         );
      end
   endgenerate

   // Top level source; disabled means held clear and idle at its inactive level.
   nic_ext_detect u_tli (
      .pclk    (pclk),
      .presetn (presetn),
      .pin     (tli_en ? tli_pin : ~tli_sens),
      .sens    (tli_sens ? `NIC_SENS_RISE : `NIC_SENS_FALL),
      .clr     (tli_clr | ~tli_en),
      .pend    (tli_pend)
   );

   // Pending latches per vector and their halt wake capability.
   always @* begin
      pend     = periph_irq; // R23
      wake_src = periph_irq & (active_halt_mode ? `NIC_WAKE_ACTIVE : `NIC_WAKE_HALT); // R16
      for (i = 0; i < NEXT; i = i + 1) begin
         pend[i+`NIC_EXT_FIRST]     = pend[i+`NIC_EXT_FIRST] | ext_pend[i];
         wake_src[i+`NIC_EXT_FIRST] = wake_src[i+`NIC_EXT_FIRST] | ext_pend[i]; // R17
      end
      pend[`NIC_EXT_FIRST+1] = pend[`NIC_EXT_FIRST+1] | aux_volt_detect;
      wake_ok = in_halt ? wake_src : {NVEC{1'b1}};
   end

   // Ranks eligible vectors: software level first, then vector number.
   always @* begin
      found    = 1'b0;
      best_lvl = 2'h0;
      best_idx = 4'h0;
      for (j = 1; j < NVEC; j = j + 1) begin // R10
         if (pend[j] && wake_ok[j] && (lvl(prio[2*j+:2]) > lvl(cc))) begin // R22
            if (!found || (lvl(prio[2*j+:2]) > best_lvl)) begin // R15
               found    = 1'b1; // R11
               best_lvl = lvl(prio[2*j+:2]);
               best_idx = j[3:0];
            end
         end
      end
   end

   // Next level, service pulse and latch clears.
   always @* begin
      next_cc  = cc;
      next_svc = 1'b0;
      next_vec = svc_vector;
      ext_clr  = {NEXT{1'b0}};
      tli_clr  = 1'b0;
      if (irq_return_instr || pop_cc_instr)
         next_cc = stack_prio; // R12
      else if (irq_enable_instr || halt_instr || wait_for_irq_instr)
         next_cc = `NIC_CODE_L0; // R14
      else if (irq_disable_instr)
         next_cc = `NIC_CODE_L3;
      if (trap_instr) begin
         next_cc  = `NIC_CODE_L3; // R08
         next_svc = 1'b1;
         next_vec = `NIC_VEC_TRAP;
      end else if (instr_end && tli_pend) begin
         next_cc  = `NIC_CODE_L3; // R09
         next_svc = 1'b1;
         next_vec = `NIC_VEC_TOP;
         tli_clr  = 1'b1;
      end else if (instr_end && found) begin
         next_cc  = prio[2*best_idx+:2]; // R03
         next_svc = 1'b1;
         next_vec = `NIC_VEC_TOP - {11'h0, best_idx, 1'b0}; // R06
         for (k = 0; k < NEXT; k = k + 1)
            if (best_idx == k + `NIC_EXT_FIRST)
               ext_clr[k] = 1'b1;
      end
      for (k = 0; k < NEXT; k = k + 1)
         if (apb_wr && (idx == `NIC_IDX_EXTSENS) && (cc == `NIC_CODE_L3) &&
             (pwdata[2*k+:2] != ext_sens[2*k+:2]))
            ext_clr[k] = 1'b1; // R20
   end

   // Level register and service outputs.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cc_prio_hi       <= 1'b1; // R04
         cc_prio_lo       <= 1'b1;
         level3_jump_take <= 1'b1;
         svc_valid        <= 1'b0;
         svc_vector       <= 16'h0000;
         wake_req         <= 1'b0;
      end else begin
         cc_prio_hi       <= next_cc[1]; // R01
         cc_prio_lo       <= next_cc[0];
         level3_jump_take <= (next_cc == `NIC_CODE_L3); // R13
         svc_valid        <= next_svc;
         svc_vector       <= next_vec;
         wake_req         <= in_halt & ((|(pend & wake_src)) | tli_pend);
      end
   end

   // Register writes.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prio     <= {(2*NVEC){1'b1}}; // R05
         ext_sens <= `NIC_RST_EXTSENS;
         tli_sens <= 1'b0;
         tli_en   <= 1'b0;
      end else if (apb_wr) begin
         for (n = 0; n < 4; n = n + 1)
            if (idx == `NIC_IDX_SW_PRIORITY_0 + n)
               prio[8*n+0+:2] <= merge(prio[8*n+0+:2], pwdata[1:0]);
         for (n = 0; n < 4; n = n + 1)
            if ((idx == `NIC_IDX_SW_PRIORITY_0 + n) && (n < 3)) begin
               prio[8*n+2+:2] <= merge(prio[8*n+2+:2], pwdata[3:2]);
               prio[8*n+4+:2] <= merge(prio[8*n+4+:2], pwdata[5:4]);
               prio[8*n+6+:2] <= merge(prio[8*n+6+:2], pwdata[7:6]);
            end
         if (idx == `NIC_IDX_SW_PRIORITY_3)
            prio[2*NVEC-1-:2] <= merge(prio[2*NVEC-1-:2], pwdata[3:2]);
         if ((idx == `NIC_IDX_EXTSENS) && (cc == `NIC_CODE_L3))
            ext_sens <= pwdata[7:0]; // R19
         if (idx == `NIC_IDX_TLICTL) begin
            tli_en <= pwdata[0];
            if (!tli_en)
               tli_sens <= pwdata[1];
         end
      end
   end

   // Read data selection.
   always @* begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      case (idx)
         `NIC_IDX_CC:
            rd_mux[7:0] = {2'h3, cc_prio_hi, 1'b0, cc_prio_lo, 3'h2};
         `NIC_IDX_SW_PRIORITY_0:   rd_mux[7:0] = prio[7:0];
         `NIC_IDX_SW_PRIORITY_1:   rd_mux[7:0] = prio[15:8];
         `NIC_IDX_SW_PRIORITY_2:   rd_mux[7:0] = prio[23:16];
         `NIC_IDX_SW_PRIORITY_3:   rd_mux[7:0] = {4'hf, prio[27:24]}; // R05
         `NIC_IDX_EXTSENS: rd_mux[7:0] = ext_sens;
         `NIC_IDX_TLICTL:  rd_mux[1:0] = {tli_sens, tli_en};
         `NIC_IDX_STATUS:
            rd_mux[17:0] = {wake_req, tli_pend, found, 1'b0, pend[NVEC-1:1], 1'b0};
         default:          rd_hit = 1'b0;
      endcase
   end

   // APB answer one cycle into the access phase.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & (~rd_hit | (|paddr[11:10]));
         if (apb_rd)
            prdata <= (|paddr[11:10]) ? 32'h0000_0000 : rd_mux;
      end
   end

endmodule

// file: test/nic_src_model.sv
/*
 Peripheral request sources: a request holds until its vector is served.
 Assumes requests arrive as one-cycle pulses from the bench.
*/
`timescale 1ns/1ps
module nic_src_model (
   // Clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // Requests and service
   input  wire [13:0] raise,
   input  wire        svc_valid,
   input  wire [15:0] svc_vector,
   // Levels to the controller
   output reg  [13:0] periph_irq
);
   wire [15:0] idx = (16'hfffa - svc_vector) >> 1;
   wire [13:0] clr = svc_valid ? (14'h1 << idx) : 14'h0;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         periph_irq <= 14'h0;
      else
         periph_irq <= (periph_irq | raise) & ~clr;
   end
endmodule

// file: test/nic_top_monitor.sv
/*
 Checker of the interrupt controller's core side ports.
 Bound to nic_top; it sees only that module's ports.
*/
`timescale 1ns/1ps
`include "nic_defs.vh"
module nic_top_monitor (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // Core events
   input wire logic        instr_end,
   input wire logic        irq_enable_instr,
   input wire logic        irq_disable_instr,
   input wire logic        halt_instr,
   input wire logic        wait_for_irq_instr,
   input wire logic        trap_instr,
   input wire logic        irq_return_instr,
   input wire logic        pop_cc_instr,
   input wire logic [1:0]  stack_prio,
   input wire logic        halt_mode,
   input wire logic        active_halt_mode,
   // Service and status
   input wire logic        svc_valid,
   input wire logic [15:0] svc_vector,
   input wire logic        cc_prio_hi,
   input wire logic        cc_prio_lo,
   input wire logic        level3_jump_take,
   input wire logic        wake_req
);
   wire [1:0] cc = {cc_prio_hi, cc_prio_lo};
   wire no_svc  = !instr_end && !trap_instr;
   wire no_rest = !irq_return_instr && !pop_cc_instr;
   wire no_low  = !irq_enable_instr && !halt_instr && !wait_for_irq_instr;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   function automatic [1:0] lv(input [1:0] c);
      lv = (c == 2'h2) ? 2'h0 : ((c == 2'h0) ? 2'h2 : c);
   endfunction
   sequence s_l3; cc_prio_hi && cc_prio_lo; endsequence
   sequence s_trap; svc_valid && svc_vector == `NIC_VEC_TRAP ##0 s_l3; endsequence
   property p_trap; trap_instr |=> s_trap; endproperty
   a_trap: assert property (p_trap) else $error("trap entry wrong");
   property p_top; svc_valid && svc_vector == `NIC_VEC_TOP |-> s_l3; endproperty
   a_top: assert property (p_top) else $error("top level entry level wrong");
   property p_pulse; svc_valid |=> !svc_valid; endproperty
   a_pulse: assert property (p_pulse) else $error("service pulse too long");
   property p_jump; level3_jump_take == (cc_prio_hi && cc_prio_lo); endproperty
   a_jump: assert property (p_jump) else $error("level 3 jump flag wrong");
   property p_off; irq_disable_instr && no_svc && no_rest && no_low |=> s_l3; endproperty
   a_off: assert property (p_off) else $error("disable level wrong");
   property p_on; !no_low && no_svc && no_rest |=> cc == 2'h2; endproperty
   a_on: assert property (p_on) else $error("enable level wrong");
   property p_rest; !no_rest && no_svc |=> cc == $past(stack_prio); endproperty
   a_rest: assert property (p_rest) else $error("restored level wrong");
   property p_lvl;
      svc_valid && svc_vector != `NIC_VEC_TOP && svc_vector != `NIC_VEC_TRAP
         |-> lv(cc) > lv($past(cc));
   endproperty
   a_lvl: assert property (p_lvl) else $error("service below current level");
   property p_wake; !halt_mode && !active_halt_mode |=> !wake_req; endproperty
   a_wake: assert property (p_wake) else $error("wake outside halt");
endmodule
bind nic_top nic_top_monitor u_mon (.pclk(pclk), .presetn(presetn), .instr_end(instr_end),
   .irq_enable_instr(irq_enable_instr), .irq_disable_instr(irq_disable_instr),
   .halt_instr(halt_instr), .wait_for_irq_instr(wait_for_irq_instr), .trap_instr(trap_instr),
   .irq_return_instr(irq_return_instr), .pop_cc_instr(pop_cc_instr), .stack_prio(stack_prio),
   .halt_mode(halt_mode), .active_halt_mode(active_halt_mode), .svc_valid(svc_valid),
   .svc_vector(svc_vector), .cc_prio_hi(cc_prio_hi), .cc_prio_lo(cc_prio_lo),
   .level3_jump_take(level3_jump_take), .wake_req(wake_req));

// file: test/test_nested_priority_interrupt_ctrl.sv
/*
 Bench of the interrupt controller: registers, ranking, service,
 external and top level sources, halt wake.
 Assumes the design, its header and the source model are compiled first.
*/
`timescale 1ns/1ps
`include "nic_defs.vh"
module test_nested_priority_interrupt_ctrl;
   reg         pclk, presetn, psel, penable, pwrite, halt_mode, aux_volt_detect, tli_pin, er;
   reg         active_halt_mode;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rd;
   reg  [7:0]  ev;
   reg  [1:0]  stack_prio;
   reg  [3:0]  ext_pin;
   reg  [13:0] raise;
   wire [31:0] prdata;
   wire        pready, pslverr, svc_valid, cc_prio_hi, cc_prio_lo, wake_req;
   wire [15:0] svc_vector;
   wire [13:0] periph_irq;
   integer     num_errors, cmp_count, cycles, i;
   nic_top u_nic_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .instr_end(ev[0]), .irq_enable_instr(ev[1]),
      .irq_disable_instr(ev[2]), .halt_instr(ev[3]), .wait_for_irq_instr(ev[4]),
      .trap_instr(ev[5]), .irq_return_instr(ev[6]), .pop_cc_instr(ev[7]),
      .stack_prio(stack_prio), .halt_mode(halt_mode), .active_halt_mode(active_halt_mode),
      .periph_irq(periph_irq), .aux_volt_detect(aux_volt_detect), .ext_pin(ext_pin),
      .tli_pin(tli_pin), .svc_valid(svc_valid), .svc_vector(svc_vector),
      .cc_prio_hi(cc_prio_hi), .cc_prio_lo(cc_prio_lo), .level3_jump_take(),
      .wake_req(wake_req));
   nic_src_model u_nic_src_model (.pclk(pclk), .presetn(presetn), .raise(raise),
      .svc_valid(svc_valid), .svc_vector(svc_vector), .periph_irq(periph_irq));
   task finish_test;
      begin
         if (num_errors == 0 && cmp_count > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task chk(input string nm, input [31:0] ex, input [31:0] got);
      begin
         cmp_count = cmp_count + 1;
         if (got !== ex) begin
            num_errors = num_errors + 1;
            $display("unexpected %0s expected %h seen %h", nm, ex, got);
         end
      end
   endtask
   task apb(input w, input [7:0] idx, input [31:0] d);
      begin
         @(posedge pclk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= {2'h0, idx, 2'h0};
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1)
            @(posedge pclk);
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task rdc(input string nm, input [7:0] idx, input [31:0] mk, input [31:0] ex);
      begin
         apb(1'b0, idx, 32'h0);
         chk(nm, ex, rd & mk);
      end
   endtask
   task svc(input [7:0] m, input v, input [15:0] vec, input [1:0] cc);
      begin
         @(posedge pclk);
         ev <= m;
         @(posedge pclk);
         ev <= 8'h0;
         #1;
         chk("svc_valid", {31'h0, v}, {31'h0, svc_valid});
         chk("cc", {30'h0, cc}, {30'h0, cc_prio_hi, cc_prio_lo});
         if (v)
            chk("svc_vector", {16'h0, vec}, {16'h0, svc_vector});
      end
   endtask
   task raise_v(input [13:0] m);
      begin
         @(posedge pclk);
         raise <= m;
         @(posedge pclk);
         raise <= 14'h0;
         repeat (2) @(posedge pclk);
      end
   endtask
   task t_regs;
      begin
         rdc("cc", `NIC_IDX_CC, 32'hffffffff, 32'hea);
         for (i = 0; i < 4; i = i + 1)
            rdc("ispr", `NIC_IDX_SW_PRIORITY_0 + i[7:0], 32'hffffffff, 32'hff);
         rdc("unmapped", 8'h2c, 32'hffffffff, 32'h0);
         chk("pslverr", 32'h1, {31'h0, er});
         apb(1'b1, `NIC_IDX_SW_PRIORITY_3, 32'h0);
         rdc("sw_priority_3", `NIC_IDX_SW_PRIORITY_3, 32'hff, 32'hf0);
         apb(1'b1, `NIC_IDX_SW_PRIORITY_1, 32'hcf);
         apb(1'b1, `NIC_IDX_SW_PRIORITY_1, 32'h64);
         rdc("sw_priority_1", `NIC_IDX_SW_PRIORITY_1, 32'hff, 32'h44);
      end
   endtask
   task t_service;
      begin
         apb(1'b1, `NIC_IDX_SW_PRIORITY_2, 32'hf5);
         raise_v(14'h0300);
         svc(8'h01, 1'b0, 16'h0, 2'h3);
         svc(8'h02, 1'b0, 16'h0, 2'h2);
         svc(8'h01, 1'b1, 16'hffea, 2'h1);
         svc(8'h01, 1'b0, 16'h0, 2'h1);
         svc(8'h40, 1'b0, 16'h0, 2'h2);
         svc(8'h01, 1'b1, 16'hffe8, 2'h1);
         svc(8'h80, 1'b0, 16'h0, 2'h2);
         svc(8'h10, 1'b0, 16'h0, 2'h2);
         svc(8'h04, 1'b0, 16'h0, 2'h3);
         svc(8'h20, 1'b1, `NIC_VEC_TRAP, 2'h3);
      end
   endtask
   task t_ext;
      begin
         apb(1'b1, `NIC_IDX_EXTSENS, 32'h01);
         @(posedge pclk);
         ext_pin <= 4'he;
         repeat (2) @(posedge pclk);
         ext_pin <= 4'hf;
         repeat (3) @(posedge pclk);
         rdc("pending", `NIC_IDX_STATUS, 32'h4, 32'h4);
         apb(1'b1, `NIC_IDX_EXTSENS, 32'h02);
         rdc("pending", `NIC_IDX_STATUS, 32'h4, 32'h0);
      end
   endtask
   task t_tli;
      begin
         apb(1'b1, `NIC_IDX_TLICTL, 32'h2);
         apb(1'b1, `NIC_IDX_TLICTL, 32'h3);
         @(posedge pclk);
         tli_pin <= 1'b1;
         repeat (3) @(posedge pclk);
         svc(8'h01, 1'b1, `NIC_VEC_TOP, 2'h3);
      end
   endtask
   task t_wake;
      begin
         @(posedge pclk);
         halt_mode <= 1'b1;
         aux_volt_detect <= 1'b1;
         raise_v(14'h1002);
         #1;
         chk("wake_req", 32'h0, {31'h0, wake_req});
         @(posedge pclk);
         halt_mode <= 1'b0;
         active_halt_mode <= 1'b1;
         repeat (2) @(posedge pclk);
         #1;
         chk("wake_req", 32'h1, {31'h0, wake_req});
         @(posedge pclk);
         halt_mode <= 1'b1;
         active_halt_mode <= 1'b0;
         raise_v(14'h0100);
         #1;
         chk("wake_req", 32'h1, {31'h0, wake_req});
      end
   endtask
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles = cycles + 1;
      if (cycles == 5000) begin
         num_errors = num_errors + 1;
         finish_test;
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, ev, halt_mode} = 0;
      active_halt_mode = 1'b0;
      {aux_volt_detect, tli_pin, raise, num_errors, cmp_count, cycles} = 0;
      stack_prio = 2'h2;
      ext_pin = 4'hf;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_service;
      t_ext;
      t_tli;
      t_wake;
      finish_test;
   end
endmodule
